// ==== lcd_drive_pkg.sv ====
package lcd_drive_pkg;
  // ==========================================
  // divider and geometry
  localparam int unsigned CLK_DIV = 8;      // drive tick = slow clock / 8
  localparam int unsigned MAX_COMS = 4;
  localparam int unsigned NUM_SEGS = 8;
  // ==========================================
  // drive level codes (0 = ground, 3 = top level)
  localparam logic [1:0] LVL_VSS = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;
  // ==========================================
  // control reset values
  localparam logic RST_ENABLE = 1'h0;
  localparam logic RST_TYPE = 1'h0;
  localparam logic RST_STYLE = 1'h0;
  // ==========================================
  // pump source codes
  localparam logic [1:0] PUMP_EXT_PIN = 2'h0;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_PHASE0 = 3'b010,
    ST_PHASE1 = 3'b100
  } drive_state_t;
endpackage

// ==== tick_if.sv ====
`timescale 1ns/1ps
// ==========================================
// tick carrier between divider and sequencer
interface tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface

// ==== drive_divider.sv ====
`timescale 1ns/1ps
module drive_divider
  import lcd_drive_pkg::*;
(
  input wire logic mclk,                 // system clock
  input wire logic reset_n,              // async reset
  input wire logic slow_subsystem_clock, // slow clock, synchronised here
  tick_if.src t                          // tick out
);
  logic s1, s2, s3;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic next_tick;
  logic tick_q;

  // ==========================================
  // three-stage sync, rising edge counted by divide-by-8
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!t.run) begin
      next_cnt = 3'h0;
    end else if (s2 && !s3) begin
      next_cnt = cnt + 3'h1;
      next_tick = (cnt == 3'(CLK_DIV - 1));
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cnt <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      s1 <= slow_subsystem_clock;
      s2 <= s1;
      s3 <= s2;
      cnt <= next_cnt;
      tick_q <= next_tick;
    end
  end

  assign t.tick = tick_q;
endmodule

// ==== lcd_panel_drive_control.sv ====
`timescale 1ns/1ps
module lcd_panel_drive_control
  import lcd_drive_pkg::*;
(
  input wire logic mclk,                      // 200 MHz clock
  input wire logic reset_n,                   // async reset, active low
  input wire logic slow_subsystem_clock,      // slow clock pin
  input wire logic display_drive_enable,      // driver enable
  input wire logic sleep_mode,                // chip asleep
  input wire logic duty_select,               // 0: 1/3, 1: 1/4 duty
  input wire logic wave_type,                 // 0: first, 1: second
  input wire logic bias_third,                // 0: 1/2, 1: 1/3 bias
  input wire logic bias_style_select,         // 0: resistor, 1: cap
  input wire logic [1:0] bias_resistor_select,// resistor value code
  input wire logic [1:0] pump_source_select,  // pump supply code
  input wire logic [NUM_SEGS*MAX_COMS-1:0] seg_mem, // pixel bits
  output logic [MAX_COMS*2-1:0] com_level,    // common level codes
  output logic [NUM_SEGS*2-1:0] seg_level,    // segment level codes
  output logic [3:0] com_active,              // commons in use
  output logic bias_on,                       // bias network powered
  output logic [1:0] resistor_sel_out,        // resistor tap select
  output logic pump_enable,                   // charge pump on
  output logic pump_internal,                 // internal pump source
  output logic third_bias_out,                // four-level ladder
  output logic driver_reset,                  // driver in reset
  output logic enable_status                  // enable readback
);
  tick_if t ();

  drive_divider u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .slow_subsystem_clock(slow_subsystem_clock),
    .t(t)
  );

  drive_state_t state, next_state;
  logic [1:0] slot, next_slot;
  logic frame_pol, next_frame_pol;
  logic hold;

  // ==========================================
  // level for a common or segment given selection and polarity
  function automatic logic [1:0] lvl(input logic sel, input logic pol,
                                     input logic third, input logic is_com);
    logic [1:0] v;
    v = LVL_VSS;
    if (third) begin
      if (is_com) v = sel ? LVL_TOP : LVL_LOW;
      else v = sel ? LVL_VSS : LVL_MID;
    end else begin
      if (is_com) v = sel ? LVL_TOP : LVL_MID;
      else v = sel ? LVL_VSS : LVL_MID;
    end
    // inverted half: mirror about mid level for zero dc
    if (pol) v = 2'(LVL_TOP - v);
    if (!third && v == LVL_LOW) v = LVL_MID;
    return v;
  endfunction

  // ==========================================
  // driver reset and enable
  assign hold = !display_drive_enable || sleep_mode;
  assign t.run = !hold;

  // ==========================================
  // slot and polarity sequencer
  always_comb begin
    next_state = state;
    next_slot = slot;
    next_frame_pol = frame_pol;
    case (state)
      ST_OFF: begin
        next_slot = 2'h0;
        next_frame_pol = 1'b0;
        if (!hold) next_state = ST_PHASE0;
      end
      ST_PHASE0, ST_PHASE1: begin
        if (hold) begin
          next_state = ST_OFF;
        end else if (t.tick) begin
          if (wave_type) begin
            next_state = ST_PHASE0;
            // second variant: one tick per slot, polarity per frame
            if (slot == (duty_select ? 2'h3 : 2'h2)) begin
              next_slot = 2'h0;
              next_frame_pol = !frame_pol;
            end else begin
              next_slot = slot + 2'h1;
            end
          end else if (state == ST_PHASE0) begin
            next_state = ST_PHASE1; // first variant: inverted half
          end else begin
            next_state = ST_PHASE0;
            if (slot == (duty_select ? 2'h3 : 2'h2)) begin
              next_slot = 2'h0;
            end else begin
              next_slot = slot + 2'h1;
            end
          end
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
      slot <= 2'h0;
      frame_pol <= 1'b0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      frame_pol <= next_frame_pol;
    end
  end

  // ==========================================
  // output levels and control outputs
  logic [MAX_COMS*2-1:0] next_com;
  logic [NUM_SEGS*2-1:0] next_seg;
  logic pol;

  always_comb begin
    pol = wave_type ? frame_pol : (state == ST_PHASE1);
    next_com = '0;
    next_seg = '0;
    if (state != ST_OFF && !hold) begin
      for (int c = 0; c < MAX_COMS; c++) begin
        if (c < 3 || duty_select) begin
          next_com[c*2 +: 2] = lvl(slot == 2'(c), pol, bias_third, 1'b1);
        end
      end
      for (int s = 0; s < NUM_SEGS; s++) begin
        next_seg[s*2 +: 2] = lvl(seg_mem[s*MAX_COMS + slot], pol,
                                 bias_third, 1'b0);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      com_level <= '0;
      seg_level <= '0;
      com_active <= 4'h0;
      bias_on <= 1'b0;
      resistor_sel_out <= 2'h0;
      pump_enable <= 1'b0;
      pump_internal <= 1'b0;
      third_bias_out <= 1'b0;
      driver_reset <= 1'b1;
      enable_status <= RST_ENABLE;
    end else begin
      com_level <= next_com;
      seg_level <= next_seg;
      com_active <= hold ? 4'h0 : (duty_select ? 4'hf : 4'h7);
      bias_on <= !hold;
      resistor_sel_out <= bias_resistor_select;
      pump_enable <= !hold && bias_style_select;
      pump_internal <= !hold && bias_style_select &&
                       (pump_source_select != PUMP_EXT_PIN);
      third_bias_out <= bias_third;
      driver_reset <= hold;
      enable_status <= display_drive_enable;
    end
  end
endmodule

// ==== lcd_panel_model.sv ====
`timescale 1ns/1ps
// ==========================================
// passive panel pixel, segment 0 on common 0
module lcd_panel_model (
  input wire logic [1:0] com, // common level
  input wire logic [1:0] seg, // segment level
  output logic pixel_on       // full swing across pixel
);
  // full swing means one end at ground, the other at top
  assign pixel_on = ((com ^ seg) == 2'h3) && (com[0] == com[1]);
endmodule

// ==== lcd_panel_drive_control_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// port checks
module lcd_panel_drive_control_assertions
  import lcd_drive_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic display_drive_enable,
  input wire logic sleep_mode,
  input wire logic duty_select,
  input wire logic bias_style_select,
  input wire logic [1:0] bias_resistor_select,
  input wire logic [1:0] pump_source_select,
  input wire logic [7:0] com_level,
  input wire logic [15:0] seg_level,
  input wire logic [3:0] com_active,
  input wire logic pump_enable,
  input wire logic pump_internal,
  input wire logic [1:0] resistor_sel_out,
  input wire logic driver_reset,
  input wire logic enable_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // driver running when enabled and awake
  wire on = display_drive_enable && !sleep_mode;
  property p_rst; !on |=> driver_reset; endproperty
  a_rst: assert property (p_rst) else $error("reset not held");
  property p_run; on |=> !driver_reset; endproperty
  a_run: assert property (p_run) else $error("reset stuck");
  property p_d4; (on && duty_select)[*3] |-> com_active == 4'hf; endproperty
  a_d4: assert property (p_d4) else $error("four commons");
  property p_d3; (on && !duty_select)[*3] |-> com_active == 4'h7; endproperty
  a_d3: assert property (p_d3) else $error("three commons");
  property p_pump; on |=> pump_enable == $past(bias_style_select); endproperty
  a_pump: assert property (p_pump) else $error("pump");
  property p_int;
    on && bias_style_select |=> pump_internal == |$past(pump_source_select);
  endproperty
  a_int: assert property (p_int) else $error("pump source");
  property p_blank;
    (!display_drive_enable)[*3] |-> com_level == 8'h0 && seg_level == 16'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("not blank");
  property p_en; ##1 enable_status == $past(display_drive_enable); endproperty
  a_en: assert property (p_en) else $error("enable readback");
  property p_tap; on |=> resistor_sel_out == $past(bias_resistor_select);
  endproperty
  a_tap: assert property (p_tap) else $error("resistor tap");
  c_run: cover property (on [*8]);
  c_pump: cover property (on && bias_style_select ##1 pump_internal);
  c_sleep: cover property (display_drive_enable && sleep_mode);
endmodule

// ==== lcd_panel_drive_control_test.sv ====
`timescale 1ns/1ps
module lcd_panel_drive_control_test;
  import lcd_drive_pkg::*;
  logic mclk = 0, reset_n = 0, slow_subsystem_clock = 0;
  logic display_drive_enable = 0, sleep_mode = 0, duty_select = 0;
  logic wave_type = 0, bias_third = 1, bias_style_select = 0;
  logic [1:0] bias_resistor_select = 0, pump_source_select = 0, c0;
  logic [31:0] seg_mem = 0;
  logic [7:0] com_level;
  logic [15:0] seg_level;
  logic [3:0] com_active;
  logic bias_on, pump_enable, pump_internal, third_bias_out;
  logic driver_reset, enable_status, pixel_on;
  logic [1:0] resistor_sel_out;
  int num_errors = 0, comparisons = 0, cyc = 0;
  // {enable, sleep, duty, style, source} -> {reset, commons, pump, internal}
  logic [12:0] rows [8] = '{13'h0040, 13'h1a40, 13'h101c, 13'h163e,
    13'h129f, 13'h173f, 13'h17bf, 13'h15bc};
  lcd_panel_drive_control u_dut (.*);
  lcd_panel_model u_panel (.com(com_level[1:0]), .seg(seg_level[1:0]),
    .pixel_on(pixel_on));
  initial forever #2.5 mclk = ~mclk;
  // slow clock, period ten system cycles
  always begin
    repeat (5) @(negedge mclk);
    slow_subsystem_clock = ~slow_subsystem_clock;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    check({driver_reset, enable_status}, 16'h2);
    reset_n = 1;
    // control table
    for (int i = 0; i < 8; i++) begin
      {display_drive_enable, sleep_mode, duty_select, bias_style_select,
        pump_source_select} = rows[i][12:7];
      bias_resistor_select = i[1:0];
      repeat (4) @(negedge mclk);
      check({driver_reset, com_active, pump_enable, pump_internal,
        resistor_sel_out}, {rows[i][6:0], i[1:0]});
    end
    $display("control table done");
    // waveform per variant, memory set before enable
    for (int w = 0; w < 2; w++) begin
      display_drive_enable = 0;
      {duty_select, bias_style_select, wave_type} = {2'h0, w[0]};
      seg_mem = 32'hffffffff;
      repeat (4) @(negedge mclk);
      display_drive_enable = 1;
      repeat (40) @(negedge mclk);
      check(pixel_on, 16'h1);
      check({bias_on, third_bias_out}, 16'h3);
      c0 = com_level[1:0];
      // first variant inverts one tick later, second one frame later
      repeat (w ? 240 : 80) @(negedge mclk);
      check(com_level[1:0], 2'h3 - c0);
      display_drive_enable = 0;
      repeat (4) @(negedge mclk);
      check({com_level, seg_level, bias_on} == 25'h0, 16'h1);
      $display("waveform variant %0d done", w);
    end
    results();
  end
endmodule
bind lcd_panel_drive_control lcd_panel_drive_control_assertions u_chk (.*);
